/* File: design/asp_regs.vh */
// Purpose: constants of the asynchronous serial port (register map, fields, codes)
// Assumes: 8-bit register port with a 2-bit address
// Notes: all offsets, field positions and reset values live here
// How it works
// - rx_char_ready is set while a character waits, cleared by reading the last waiting character from receive data.
// - tx_buffer_empty is set when the buffer empties and after reset; load clears it.
// - loop_back_on feeds transmit data to the receiver and ignores the receive pin.
// - clock_ratio codes 00..11 give 1, 16, 32, 64 clocks per bit, both directions.
// - clock_source_sel 1 takes the timer pulse, 0 takes the timer's external input line.
// - Parity is even when even_sel is 1, odd when even_sel is 0.
// - check_bit_on adds a parity bit; receiver keeps it unless characters are 8 bits.
// - char_length codes 00..11 give 5, 6, 7, 8 data bits.
// - force_char_mode sends a whole character time at force_level for each loaded character.
// - hold_spacing drives the transmit line low at once; clearing it returns to marking, or to the current frame bit while a character is still shifting.
// - Transmitter sends two stops when stop_count_sel is 1; receiver checks one stop.
// - Transmitter requests an interrupt on an empty buffer only when irq_allow is 1.
// - unit_on 0 stops transmission and holds marking, but finishes a started character.
// - any_rx_fault is the OR of parity, overrun and framing fault flags.
// - A missing stop bit sets frame_fault and waits half a bit, one bit at ratio 1, before hunting again.
// - A parity mismatch sets the parity flag, which stays until software clears it.
// - A third unread arrival is flagged overrun; reading it latches overrun until cleared.
// - Receiver requests an interrupt on a fault or a waiting character when irq_allow is 1.
// - Writing rx_ctrl_stat clears latched parity and overrun indications.
// - Above ratio 1 a start bit must stay low half a bit and later bits are sampled mid-bit; at ratio 1 the low tick starts the data bits.
// - Received characters shorter than 8 bits, counting a kept parity bit, are padded with ones at the top.
// - An idle transmitter holds its output high.
`ifndef ASP_REGS_VH
`define ASP_REGS_VH

`define ASP_ADDR_LINE    2'h0
`define ASP_ADDR_TX      2'h1
`define ASP_ADDR_RX      2'h2
`define ASP_ADDR_DATA    2'h3

`define ASP_LINE_RESET   8'h00
`define ASP_LS_LOOP      0
`define ASP_LS_RATIO     2:1
`define ASP_LS_SRC       3
`define ASP_LS_EVEN      4
`define ASP_LS_PAR       5
`define ASP_LS_LEN       7:6

`define ASP_TX_RESET     7'h00
`define ASP_TX_EMPTY     0
`define ASP_TX_LEVEL     1
`define ASP_TX_FORCE     2
`define ASP_TX_BREAK     3
`define ASP_TX_STOP2     4
`define ASP_TX_IEN       6
`define ASP_TX_EN        7

`define ASP_RX_RESET     2'h0
`define ASP_RX_ERR       0
`define ASP_RX_FE        1
`define ASP_RX_PE        2
`define ASP_RX_OVR       3
`define ASP_RX_READY     4
`define ASP_RX_IEN       6
`define ASP_RX_EN        7

`define ASP_RATIO_X1     2'h0
`define ASP_RATIO_X16    2'h1
`define ASP_RATIO_X32    2'h2
`define ASP_TICKS_X1     7'h01
`define ASP_TICKS_X16    7'h10
`define ASP_TICKS_X32    7'h20
`define ASP_TICKS_X64    7'h40
`define ASP_MIN_BITS     4'h5

`endif

/* File: design/asp_tick.v */
// Purpose: select the serial bit clock source and turn it into one-cycle ticks
// Assumes: timer pulse is on ref_clk already; the external line is asynchronous
// Notes: a tick marks one rising edge of the selected serial clock
`timescale 1ns/100ps
`include "asp_regs.vh"

module asp_tick (
	input  wire ref_clk,     // System clock
	input  wire rst,         // Synchronous reset, active high
	input  wire ext_clk_in,  // Timer external input line, asynchronous
	input  wire timer_pulse, // Timer output pulse, same domain
	input  wire src_sel,     // 1 selects timer pulse
	output reg  tick         // One-cycle serial clock event
);

	reg ext_s1;
	reg ext_s2;
	reg ext_s3;

	always @(posedge ref_clk) begin
		if (rst) begin
			ext_s1 <= 1'b0;
			ext_s2 <= 1'b0;
			ext_s3 <= 1'b0;
			tick   <= 1'b0;
		end else begin
			ext_s1 <= ext_clk_in;
			ext_s2 <= ext_s1;
			ext_s3 <= ext_s2;
			tick   <= src_sel ? timer_pulse : (ext_s2 & ~ext_s3);
		end
	end

endmodule // asp_tick

/* File: design/asp_tx.v */
// Purpose: transmit buffer and shifter of the asynchronous serial port
// Assumes: tick is a one-cycle event; bit_ticks ticks make one bit time
// Notes: the line is registered, so break and idle show one cycle after the cause
`timescale 1ns/100ps
`include "asp_regs.vh"

module asp_tx (
	input  wire       ref_clk,         // System clock
	input  wire       rst,             // Synchronous reset, active high
	input  wire       tick,            // Serial clock event
	input  wire [6:0] bit_ticks,       // Ticks per bit
	input  wire       load,            // Write of a character
	input  wire [7:0] load_data,       // Character written
	input  wire [1:0] char_length,     // Data bits code
	input  wire       check_bit_on,    // Parity present
	input  wire       even_sel,        // Even parity
	input  wire       stop_count_sel,  // Two stop bits
	input  wire       force_char_mode, // Send constant characters
	input  wire       force_level,     // Level of constant characters
	input  wire       hold_spacing,    // Break
	input  wire       unit_on,         // Transmitter enable
	output reg        txd,             // Serial output
	output wire       tx_buffer_empty  // Buffer has no character
);

	reg        buf_full;
	reg [7:0]  buf_data;
	reg        busy;
	reg [11:0] frame;
	reg [3:0]  bits_left;
	reg [6:0]  cnt;
	wire [3:0] nb = {2'b00, char_length} + `ASP_MIN_BITS;

	function [11:0] tx_frame;
		input [7:0] d;
		input [3:0] n;
		input       par;
		input       even;
		reg   [7:0] m;
		integer     i;
		begin
			m = 8'h00;
			tx_frame = 12'hffe;
			for (i = 0; i < 8; i = i + 1) begin
				if (i < n) begin
					tx_frame[i + 1] = d[i];
					m[i] = d[i];
				end
			end
			if (par)
				tx_frame[n + 4'd1] = ^m ^ ~even;
		end
	endfunction

	assign tx_buffer_empty = ~buf_full;

	always @(posedge ref_clk) begin
		if (rst) begin
			buf_full  <= 1'b0;
			buf_data  <= 8'h00;
			busy      <= 1'b0;
			frame     <= 12'hfff;
			bits_left <= 4'h0;
			cnt       <= 7'h00;
			txd       <= 1'b1;
		end else begin
			if (load) begin
				buf_full <= 1'b1;
				buf_data <= load_data;
			end
			if (!busy) begin
				if (buf_full && unit_on && !load) begin
					busy      <= 1'b1;
					buf_full  <= 1'b0;
					frame     <= force_char_mode ? {12{force_level}} :
						tx_frame(buf_data, nb, check_bit_on, even_sel);
					bits_left <= nb + {3'b000, check_bit_on} + 4'd2 +
						{3'b000, stop_count_sel};
					cnt       <= 7'h00;
				end
			end else if (tick) begin
				if (cnt == bit_ticks - 7'd1) begin
					cnt       <= 7'h00;
					frame     <= {1'b1, frame[11:1]};
					bits_left <= bits_left - 4'd1;
					if (bits_left == 4'd1)
						busy <= 1'b0;
				end else begin
					cnt <= cnt + 7'd1;
				end
			end
			// Break wins over everything; idle shows marking, a disabled unit still shows its started frame
			txd <= hold_spacing ? 1'b0 : (busy ? frame[0] : 1'b1);
		end
	end

endmodule // asp_tx

/* File: design/asp_top.v */
// Purpose: asynchronous serial port with line setup, transmit and receive registers
// Assumes: register port strobes are one cycle; read data is valid the cycle after
// Notes: receive side holds two characters beyond the shifter before overrun
//
// The address-and-strobe port and the placing of the registers were chosen for this implementation.
`timescale 1ns/100ps
`include "asp_regs.vh"

module asp_top (
	input  wire       ref_clk,    // System clock, 100 MHz
	input  wire       rst,        // Synchronous reset, active high
	input  wire [1:0] reg_addr,   // Register address
	input  wire [7:0] reg_wdata,  // Write data
	input  wire       reg_wr,     // Write strobe
	input  wire       reg_rd,     // Read strobe
	output reg  [7:0] reg_rdata,  // Read data, cycle after the strobe
	input  wire       rxd,        // Receive pin
	output wire       txd,        // Transmit pin
	input  wire       ct1_pulse,  // Timer 1 output pulse
	input  wire       ct1_ext_in, // Timer 1 external input line
	output wire       tx_irq,     // Transmitter interrupt request
	output wire       rx_irq      // Receiver interrupt request
);

	localparam RX_IDLE  = 3'h0;
	localparam RX_START = 3'h1;
	localparam RX_DATA  = 3'h2;
	localparam RX_STOP  = 3'h3;
	localparam RX_FEXT  = 3'h4;

	reg [7:0] line_setup;
	reg [7:1] tx_ctl;
	reg [7:6] rx_ctl;

	wire       tick;
	wire       tx_empty;
	wire       wr_line = reg_wr && (reg_addr == `ASP_ADDR_LINE);
	wire       wr_tx   = reg_wr && (reg_addr == `ASP_ADDR_TX);
	wire       wr_rx   = reg_wr && (reg_addr == `ASP_ADDR_RX);
	wire       wr_data = reg_wr && (reg_addr == `ASP_ADDR_DATA);
	wire       rd_data = reg_rd && (reg_addr == `ASP_ADDR_DATA);
	wire [1:0] char_length = line_setup[`ASP_LS_LEN];
	wire       check_bit_on = line_setup[`ASP_LS_PAR];
	wire       even_sel = line_setup[`ASP_LS_EVEN];
	wire       loop_back_on = line_setup[`ASP_LS_LOOP];

	function [6:0] ratio_ticks;
		input [1:0] code;
		begin
			case (code)
				`ASP_RATIO_X1:  ratio_ticks = `ASP_TICKS_X1;
				`ASP_RATIO_X16: ratio_ticks = `ASP_TICKS_X16;
				`ASP_RATIO_X32: ratio_ticks = `ASP_TICKS_X32;
				default:        ratio_ticks = `ASP_TICKS_X64;
			endcase
		end
	endfunction

	// Keeps the received bits at the bottom, ones above them
	function [7:0] rx_align;
		input [7:0] sh;
		input [3:0] n;
		reg   [3:0] gap;
		begin
			gap = (n > 4'd8) ? 4'd0 : 4'd8 - n;
			rx_align = (sh >> gap) | ~(8'hff >> gap);
		end
	endfunction

	wire [6:0] bit_ticks = ratio_ticks(line_setup[`ASP_LS_RATIO]);
	wire [6:0] half_m1 = (bit_ticks == `ASP_TICKS_X1) ? 7'h00 :
		{1'b0, bit_ticks[6:1]} - 7'd1;
	wire [3:0] rx_bits = {2'b00, char_length} + `ASP_MIN_BITS + {3'b000, check_bit_on};

	always @(posedge ref_clk) begin
		if (rst) begin
			line_setup <= `ASP_LINE_RESET;
			tx_ctl     <= `ASP_TX_RESET;
			rx_ctl     <= `ASP_RX_RESET;
		end else begin
			if (wr_line)
				line_setup <= reg_wdata;
			if (wr_tx)
				tx_ctl <= reg_wdata[7:1]; // Empty flag is not writable
			if (wr_rx)
				rx_ctl <= reg_wdata[7:6]; // Status bits are not writable
		end
	end

	asp_tick u_tick (
		.ref_clk     (ref_clk),
		.rst         (rst),
		.ext_clk_in  (ct1_ext_in),
		.timer_pulse (ct1_pulse),
		.src_sel     (line_setup[`ASP_LS_SRC]),
		.tick        (tick)
	);

	asp_tx u_tx (
		.ref_clk         (ref_clk),
		.rst             (rst),
		.tick            (tick),
		.bit_ticks       (bit_ticks),
		.load            (wr_data),
		.load_data       (reg_wdata),
		.char_length     (char_length),
		.check_bit_on    (check_bit_on),
		.even_sel        (even_sel),
		.stop_count_sel  (tx_ctl[`ASP_TX_STOP2]),
		.force_char_mode (tx_ctl[`ASP_TX_FORCE]),
		.force_level     (tx_ctl[`ASP_TX_LEVEL]),
		.hold_spacing    (tx_ctl[`ASP_TX_BREAK]),
		.unit_on         (tx_ctl[`ASP_TX_EN]),
		.txd             (txd),
		.tx_buffer_empty (tx_empty)
	);

	// Receive pin synchroniser; loopback bypasses it
	reg  rx_s1;
	reg  rx_s2;
	wire rx_in = loop_back_on ? txd : rx_s2;

	always @(posedge ref_clk) begin
		if (rst) begin
			rx_s1 <= 1'b1;
			rx_s2 <= 1'b1;
		end else begin
			rx_s1 <= rxd;
			rx_s2 <= rx_s1;
		end
	end

	reg [2:0] rs;
	reg [6:0] rcnt;
	reg [3:0] ridx;
	reg [7:0] rsh;
	reg       rpar;
	reg       rx_done;
	reg [7:0] rx_data;
	reg       rx_pe;
	reg       rx_fe;
	wire      at_bit = tick && (rcnt == bit_ticks - 7'd1);
	wire      at_half = tick && (rcnt == half_m1);

	always @(posedge ref_clk) begin
		if (rst || !rx_ctl[`ASP_RX_EN]) begin
			rs      <= RX_IDLE;
			rcnt    <= 7'h00;
			ridx    <= 4'h0;
			rsh     <= 8'hff;
			rpar    <= 1'b0;
			rx_done <= 1'b0;
			rx_data <= 8'h00;
			rx_pe   <= 1'b0;
			rx_fe   <= 1'b0;
		end else begin
			rx_done <= 1'b0;
			if (tick && rs != RX_IDLE)
				rcnt <= rcnt + 7'd1;
			case (rs)
				RX_IDLE: begin
					rcnt <= 7'h00;
					ridx <= 4'h0;
					rsh  <= 8'hff;
					rpar <= 1'b0;
					// At ratio 1 the clock is already bit-aligned
					if (tick && !rx_in)
						rs <= (bit_ticks == `ASP_TICKS_X1) ? RX_DATA : RX_START;
				end
				RX_START: begin
					if (at_half) begin
						rcnt <= 7'h00;
						rs   <= rx_in ? RX_IDLE : RX_DATA;
					end
				end
				RX_DATA: begin
					if (at_bit) begin
						rcnt <= 7'h00;
						rpar <= rpar ^ rx_in;
						if (ridx < 4'd8)
							rsh <= {rx_in, rsh[7:1]}; // Parity beyond 8 bits dropped
						ridx <= ridx + 4'd1;
						if (ridx == rx_bits - 4'd1)
							rs <= RX_STOP;
					end
				end
				RX_STOP: begin
					if (at_bit) begin
						rcnt    <= 7'h00;
						rx_done <= 1'b1;
						rx_data <= rx_align(rsh, rx_bits);
						rx_pe   <= check_bit_on && (rpar == even_sel);
						rx_fe   <= ~rx_in; // Only one stop is checked
						rs      <= rx_in ? RX_IDLE : RX_FEXT;
					end
				end
				RX_FEXT: begin
					if (at_half)
						rs <= RX_IDLE;
				end
				default: rs <= RX_IDLE;
			endcase
		end
	end

	// Two held characters; a third arrival overwrites the newer one as overrun
	reg       v0;
	reg [7:0] d0;
	reg       pe0;
	reg       fe0;
	reg       ov0;
	reg       v1;
	reg [7:0] d1;
	reg       pe1;
	reg       fe1;
	reg       ov1;
	reg       pe_lat;
	reg       ov_lat;
	wire      pop = rd_data && v0;

	always @(posedge ref_clk) begin
		if (rst) begin
			v0     <= 1'b0;
			d0     <= 8'h00;
			pe0    <= 1'b0;
			fe0    <= 1'b0;
			ov0    <= 1'b0;
			v1     <= 1'b0;
			d1     <= 8'h00;
			pe1    <= 1'b0;
			fe1    <= 1'b0;
			ov1    <= 1'b0;
			pe_lat <= 1'b0;
			ov_lat <= 1'b0;
		end else begin
			if (pop) begin
				v0  <= v1;
				d0  <= d1;
				pe0 <= pe1;
				fe0 <= fe1;
				ov0 <= ov1;
				v1  <= 1'b0;
			end
			if (rx_done) begin
				if (!v0 || (pop && !v1)) begin
					v0  <= 1'b1;
					d0  <= rx_data;
					pe0 <= rx_pe;
					fe0 <= rx_fe;
					ov0 <= 1'b0;
				end else begin
					v1  <= 1'b1;
					d1  <= rx_data;
					pe1 <= rx_pe;
					fe1 <= rx_fe;
					ov1 <= v1 && !pop;
				end
			end
			// A new latch event wins over a clearing write in the same cycle
			pe_lat <= (pop && pe0) || (pe_lat && !wr_rx);
			ov_lat <= (pop && ov0) || (ov_lat && !wr_rx);
		end
	end

	wire fe_now  = v0 && fe0;
	wire pe_now  = (v0 && pe0) || pe_lat;
	wire ov_now  = (v0 && ov0) || ov_lat;
	wire any_err = fe_now || pe_now || ov_now;

	wire [7:0] tx_view = {tx_ctl, tx_empty};
	wire [7:0] rx_view = {rx_ctl, 1'b0, v0, ov_now, pe_now, fe_now, any_err};

	always @(posedge ref_clk) begin
		if (rst) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			case (reg_addr)
				`ASP_ADDR_LINE: reg_rdata <= line_setup;
				`ASP_ADDR_TX:   reg_rdata <= tx_view;
				`ASP_ADDR_RX:   reg_rdata <= rx_view;
				default:        reg_rdata <= d0;
			endcase
		end else begin
			reg_rdata <= 8'h00;
		end
	end

	assign tx_irq = tx_ctl[`ASP_TX_IEN] && tx_empty;
	assign rx_irq = rx_ctl[`ASP_RX_IEN] && (v0 || any_err);

endmodule // asp_top

/* File: bench/asp_chk.sv */
// Purpose: port-level checks of the serial port
// Assumes: register map of asp_regs.vh
// Notes: mirrors the interrupt enable and break bits that software writes
`timescale 1ns/100ps
`include "asp_regs.vh"
module asp_chk (
	input wire       ref_clk,   // System clock
	input wire       rst,       // Synchronous reset
	input wire [1:0] reg_addr,  // Register address
	input wire [7:0] reg_wdata, // Write data
	input wire       reg_wr,    // Write strobe
	input wire       reg_rd,    // Read strobe
	input wire [7:0] reg_rdata, // Read data
	input wire       txd,       // Transmit pin
	input wire       tx_irq,    // Transmit request
	input wire       rx_irq     // Receive request
);
	reg  t_ien, t_brk, r_ien;
	wire rd_tx = reg_rd && reg_addr == `ASP_ADDR_TX;
	wire rd_rx = reg_rd && reg_addr == `ASP_ADDR_RX;
	always @(posedge ref_clk) begin
		if (rst) begin
			t_ien <= 1'b0;
			t_brk <= 1'b0;
			r_ien <= 1'b0;
		end else if (reg_wr && reg_addr == `ASP_ADDR_TX) begin
			t_ien <= reg_wdata[6];
			t_brk <= reg_wdata[3];
		end else if (reg_wr && reg_addr == `ASP_ADDR_RX) begin
			r_ien <= reg_wdata[6];
		end
	end
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);
	AST_IDLE_AFTER_RST: assert property ($fell(rst) |-> txd && !tx_irq && !rx_irq)
		else $error("line or requests wrong after reset");
	// The line is registered, so spacing shows one cycle after the mirrored bit
	AST_BRK: assert property (t_brk |=> !txd)
		else $error("break not spacing");
	AST_TX_IRQ_EN: assert property (tx_irq |-> t_ien)
		else $error("transmit request while disabled");
	AST_RX_IRQ_EN: assert property (rx_irq |-> r_ien)
		else $error("receive request while disabled");
	AST_LOAD_CLEARS: assert property (reg_wr && reg_addr == `ASP_ADDR_DATA && t_ien |=> !tx_irq)
		else $error("load left buffer empty");
	AST_EMPTY_READ: assert property (rd_tx && t_ien |=> reg_rdata[0] == $past(tx_irq))
		else $error("empty flag disagrees with request");
	AST_ERR_OR: assert property (rd_rx |=> reg_rdata[0] == (|reg_rdata[3:1]))
		else $error("fault summary wrong");
	AST_RX_IRQ_READ: assert property (rd_rx && r_ien |=> $past(rx_irq) == (reg_rdata[4] || reg_rdata[0]))
		else $error("receive request disagrees with status");
endmodule // asp_chk
bind asp_top asp_chk asp_chk_inst (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.txd(txd), .tx_irq(tx_irq), .rx_irq(rx_irq));

/* File: bench/asp_remote.sv */
// Purpose: remote serial device facing the port's pins
// Assumes: it listens for 8 bits then a stop bit
// Notes: a frame heard with a low stop is dropped, so a break gives no character
`timescale 1ns/100ps
module asp_remote (
	input  wire       ref_clk, // System clock
	input  wire       txd,     // Line from the port
	output reg        rxd,     // Line into the port, idle high
	output reg  [7:0] got,     // Character heard on txd
	output reg        got_v    // One-cycle pulse with got
);
	int       bt = 32; // Bit time in cycles, set by the bench
	reg [7:0] r;
	initial begin
		rxd = 1'b1;
		got = 8'h00;
		got_v = 1'b0;
	end
	task automatic send(input logic [7:0] d, input int n, input logic stop);
		@(posedge ref_clk);
		rxd <= 1'b0;
		repeat (bt) @(posedge ref_clk);
		for (int i = 0; i < n; i++) begin
			rxd <= d[i];
			repeat (bt) @(posedge ref_clk);
		end
		rxd <= stop;
		repeat (bt) @(posedge ref_clk);
		rxd <= 1'b1;
		repeat (2 * bt) @(posedge ref_clk);
	endtask
	initial forever begin
		@(negedge txd);
		repeat (bt / 2) @(posedge ref_clk);
		for (int i = 0; i < 8; i++) begin
			repeat (bt) @(posedge ref_clk);
			r[i] = txd;
		end
		repeat (bt) @(posedge ref_clk);
		if (txd === 1'b1) begin
			got <= r;
			got_v <= 1'b1;
			@(posedge ref_clk);
			got_v <= 1'b0;
		end
	end
endmodule // asp_remote

/* File: bench/test_async_serial_port_control.sv */
// Purpose: self-checking bench of the serial port
// Assumes: timer pulse every other cycle, so a bit is twice the ratio in cycles
// Notes: the external timer line follows the pulse, so both sources give one rate
`timescale 1ns/100ps
`include "asp_regs.vh"
module test_async_serial_port_control;
	reg          ref_clk, rst, reg_wr, reg_rd, ct1_pulse, rd_d, b;
	reg  [1:0]   reg_addr;
	reg  [7:0]   reg_wdata, d, v;
	wire [7:0]   reg_rdata, got;
	wire         rxd, txd, tx_irq, rx_irq, got_v;
	int          error_cnt = 0;
	int          cmp_count = 0;
	int          c, n;
	logic [7:0]  dv[3];
	logic [15:0] x;
	logic [15:0] rq[$];
	logic [7:0]  sq[$];
	asp_top asp_top_inst (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.rxd(rxd), .txd(txd), .ct1_pulse(ct1_pulse), .ct1_ext_in(ct1_pulse),
		.tx_irq(tx_irq), .rx_irq(rx_irq));
	asp_remote asp_remote_inst (.ref_clk(ref_clk), .txd(txd), .rxd(rxd), .got(got),
		.got_v(got_v));
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) ct1_pulse <= ~ct1_pulse;
	task automatic bad(input string s);
		error_cnt++;
		$display("MISMATCH %0t %s", $time, s);
	endtask
	task automatic end_sim;
		if (error_cnt == 0 && cmp_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic cmp_reg(input logic [15:0] e);
		cmp_count++;
		if ((reg_rdata & e[15:8]) !== (e[7:0] & e[15:8]))
			bad($sformatf("read %h want %h", reg_rdata, e[7:0]));
	endtask
	task automatic cmp_ser(input logic [7:0] e);
		cmp_count++;
		if (got !== e)
			bad($sformatf("line char %h want %h", got, e));
	endtask
	task automatic wr(input logic [1:0] a, input logic [7:0] w);
		@(posedge ref_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= w;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [1:0] a, input logic [7:0] e, input logic [7:0] m);
		@(posedge ref_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		rq.push_back({m, e});
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1 v = reg_rdata;
	endtask
	task automatic wait_rx;
		v = 8'h00;
		for (n = 0; n < 1000 && v[4] !== 1'b1; n++)
			rd(`ASP_ADDR_RX, 8'h00, 8'h00);
		if (v[4] !== 1'b1)
			bad("no character received");
	endtask
	task automatic drain;
		for (n = 0; n < 3000 && sq.size() > 0; n++)
			@(posedge ref_clk);
		if (sq.size() > 0)
			bad("no frame on txd");
	endtask
	task automatic tx(input logic [7:0] w, input logic [7:0] e);
		sq.push_back(e);
		wr(`ASP_ADDR_DATA, w);
		drain();
	endtask
	// Results are compared where they appear, in order of request
	always @(posedge ref_clk) begin
		rd_d <= reg_rd;
		if (rd_d) begin
			x = rq.pop_front();
			if (x[15:8] != 8'h00)
				cmp_reg(x);
		end
		if (got_v)
			cmp_ser(sq.size() > 0 ? sq.pop_front() : 8'hxx);
	end
	initial begin
		#500000;
		bad("run too long");
		end_sim();
	end
	initial begin
		rst = 1'b1;
		{reg_wr, reg_rd, ct1_pulse, rd_d, reg_addr, reg_wdata} = 14'h0000;
		repeat (5) @(posedge ref_clk);
		rst <= 1'b0;
		void'($urandom(86516));
		rd(`ASP_ADDR_TX, 8'h01, 8'hff);
		rd(`ASP_ADDR_RX, 8'h00, 8'hff);
		for (c = 0; c < 4; c++) begin
			// Remote bit time comes from the same timer, so x1 is bit-synchronous
			asp_remote_inst.bt = (c == 0) ? 2 : 16 << c;
			wr(`ASP_ADDR_LINE, {5'b11001, c[1:0], 1'b0});
			wr(`ASP_ADDR_TX, 8'hc0);
			rd(`ASP_ADDR_TX, 8'hc1, 8'hff);
			d = 8'($urandom);
			tx(d, d);
		end
		asp_remote_inst.bt = 32;
		for (c = 0; c < 2; c++) begin
			// Second pass clocks from the external timer line
			wr(`ASP_ADDR_LINE, {3'b101, c[0], !c[0], 3'b010});
			d = 8'($urandom) & 8'h7f;
			b = ^d[6:0] ^ !c[0];
			tx(d, {b, d[6:0]});
			wr(`ASP_ADDR_RX, 8'hc0);
			asp_remote_inst.send({~b, d[6:0]}, 8, 1'b1);
			wait_rx();
			rd(`ASP_ADDR_RX, 8'hd5, 8'hff);
			rd(`ASP_ADDR_DATA, {~b, d[6:0]}, 8'hff);
			rd(`ASP_ADDR_RX, 8'hc5, 8'hff);
			wr(`ASP_ADDR_RX, 8'hc0);
			rd(`ASP_ADDR_RX, 8'hc0, 8'hff);
		end
		// Character size changes only while the receiver is idle
		wr(`ASP_ADDR_LINE, 8'hca);
		d = 8'($urandom);
		asp_remote_inst.send(d, 8, 1'b0);
		wait_rx();
		rd(`ASP_ADDR_RX, 8'hd3, 8'hff);
		rd(`ASP_ADDR_DATA, d, 8'hff);
		rd(`ASP_ADDR_RX, 8'hc0, 8'hff);
		for (c = 0; c < 3; c++) begin
			dv[c] = 8'($urandom);
			asp_remote_inst.send(dv[c], 8, 1'b1);
		end
		rd(`ASP_ADDR_RX, 8'hd0, 8'hff);
		rd(`ASP_ADDR_DATA, dv[0], 8'hff);
		rd(`ASP_ADDR_RX, 8'hd9, 8'hff);
		rd(`ASP_ADDR_DATA, dv[2], 8'hff);
		rd(`ASP_ADDR_RX, 8'hc9, 8'hff);
		wr(`ASP_ADDR_RX, 8'hc0);
		rd(`ASP_ADDR_RX, 8'hc0, 8'hff);
		// Break outlasts a frame so the remote drops what it hears
		wr(`ASP_ADDR_TX, 8'hc8);
		repeat (400) @(posedge ref_clk);
		rd(`ASP_ADDR_TX, 8'hc9, 8'hff);
		wr(`ASP_ADDR_TX, 8'hc0);
		d = 8'($urandom);
		wr(`ASP_ADDR_TX, 8'h40);
		wr(`ASP_ADDR_DATA, d);
		repeat (400) @(posedge ref_clk);
		rd(`ASP_ADDR_TX, 8'h40, 8'hff);
		sq.push_back(d);
		wr(`ASP_ADDR_TX, 8'hc0);
		drain();
		wr(`ASP_ADDR_LINE, 8'hcb);
		d = 8'($urandom);
		sq.push_back(d);
		wr(`ASP_ADDR_DATA, d);
		asp_remote_inst.send(~d, 8, 1'b1);
		wait_rx();
		rd(`ASP_ADDR_DATA, d, 8'hff);
		rd(`ASP_ADDR_RX, 8'hc0, 8'hff);
		end_sim();
	end
endmodule // test_async_serial_port_control
